// ---- src/tcc_capture_compare.sv ----
`timescale 1ns/100ps
// Operation
// - three 16-bit compare channels against timer two
// - compare 0/1 match raises gated interrupt
// - compare 0/1 match sets enabled port bits 5..0
// - compare 2 match raises gated interrupt
// - compare 2 match toggles port bits 7/6
// - trigger pin 0 edge captures timer
// - trigger pin 1 edge captures timer
// - trigger pin 2 edge captures timer
// - trigger pin 3 edge captures timer
// - high bytes readable, writable, reset zero
// - capture flag or external interrupt flag
// - match sets flag; software write-one requests
module tcc_capture_compare
(
  input  wire logic                       ref_clk_in,
  input  wire logic                       rstn_in,
  input  wire tcc_pkg::tcc_sfr_req_t      sfr_req_in,
  output logic [7:0]                      sfr_rdata_out,
  output logic                            sfr_hit_out,
  input  wire logic [15:0]                timer2_value_in,
  input  wire logic [3:0]                 trigger_pin_in,
  input  wire logic [3:0]                 ext_int_event_in,
  input  wire logic [2:0]                 cmp_irq_enable_in,
  input  wire logic [3:0]                 cap_irq_enable_in,
  input  wire logic                       port_write_in,
  input  wire logic [7:0]                 port_wdata_in,
  output logic [7:0]                      compare_output_port_out,
  output logic [2:0]                      compare_irq_out,
  output logic [3:0]                      capture_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [2:0][7:0] cmp_low_q;
  logic [2:0][7:0] cmp_low_d;
  logic [2:0][7:0] cmp_high_q;
  logic [2:0][7:0] cmp_high_d;
  logic [3:0][7:0] cap_low_q;
  logic [3:0][7:0] cap_low_d;
  logic [3:0][7:0] cap_high_q;
  logic [3:0][7:0] cap_high_d;
  logic [6:0]      flags_q;
  logic [6:0]      flags_d;
  logic [7:0]      trig_ctrl_q;
  logic [7:0]      trig_ctrl_d;
  logic [7:0]      set_en_q;
  logic [7:0]      set_en_d;
  logic [7:0]      tog_en_q;
  logic [7:0]      tog_en_d;
  logic [7:0]      port_q;
  logic [7:0]      port_d;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            hit_q;
  logic            hit_d;

  logic [2:0]      cmp_hit;
  logic [3:0]      pin_rise;
  logic [3:0]      pin_fall;
  logic [3:0]      cap_enabled;
  logic [3:0]      cap_event;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = sfr_req_in.wr && (sfr_req_in.addr == a);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a == tcc_pkg::FLAGS_ADDR) || (a == tcc_pkg::TRIG_CTRL_ADDR) ||
        (a == tcc_pkg::SET_ENABLE_ADDR) || (a == tcc_pkg::TOG_ENABLE_ADDR);
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++)
    begin
      m = m || (a == tcc_pkg::CMP_LOW_ADDR[i]) || (a == tcc_pkg::CMP_HIGH_ADDR[i]);
    end
    for (int i = 0; i < tcc_pkg::NUM_CAP; i++)
    begin
      m = m || (a == tcc_pkg::CAP_LOW_ADDR[i]) || (a == tcc_pkg::CAP_HIGH_ADDR[i]);
    end
    mapped = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // compare channels and trigger pins

  genvar g;
  generate
    for (g = 0; g < tcc_pkg::NUM_CMP; g++)
    begin : g_cmp
      tcc_compare_match u_match
      (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .timer_in   (timer2_value_in),
        .value_in   ({cmp_high_q[g], cmp_low_q[g]}),
        .hit_out    (cmp_hit[g])
      );
    end
    for (g = 0; g < tcc_pkg::NUM_CAP; g++)
    begin : g_cap
      tcc_edge_sync u_sync
      (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pin_in     (trigger_pin_in[g]),
        .rise_out   (pin_rise[g]),
        .fall_out   (pin_fall[g])
      );
      // even control bit arms the rising edge, odd bit the falling edge
      assign cap_enabled[g] = trig_ctrl_q[2*g] | trig_ctrl_q[2*g+1];
      assign cap_event[g]   = (trig_ctrl_q[2*g] & pin_rise[g]) |
                              (trig_ctrl_q[2*g+1] & pin_fall[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // compare and capture registers

  always_comb
  begin
    cmp_low_d  = cmp_low_q;
    cmp_high_d = cmp_high_q;
    cap_low_d  = cap_low_q;
    cap_high_d = cap_high_q;
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++)
    begin
      if (wr_at(tcc_pkg::CMP_LOW_ADDR[i]))
      begin
        cmp_low_d[i] = sfr_req_in.wdata;
      end
      if (wr_at(tcc_pkg::CMP_HIGH_ADDR[i]))
      begin
        cmp_high_d[i] = sfr_req_in.wdata;
      end
    end
    for (int i = 0; i < tcc_pkg::NUM_CAP; i++)
    begin
      if (wr_at(tcc_pkg::CAP_LOW_ADDR[i]))
      begin
        cap_low_d[i] = sfr_req_in.wdata;
      end
      if (wr_at(tcc_pkg::CAP_HIGH_ADDR[i]))
      begin
        cap_high_d[i] = sfr_req_in.wdata;
      end
      // capture beats a software write in the same cycle
      if (cap_event[i])
      begin
        cap_high_d[i] = timer2_value_in[15:8];
        cap_low_d[i]  = timer2_value_in[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmp_low_q  <= '0;
      cmp_high_q <= '0;
      cap_low_q  <= '0;
      cap_high_q <= '0;
    end
    else
    begin
      cmp_low_q  <= cmp_low_d;
      cmp_high_q <= cmp_high_d;
      cap_low_q  <= cap_low_d;
      cap_high_q <= cap_high_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and flag registers

  always_comb
  begin
    trig_ctrl_d = trig_ctrl_q;
    set_en_d    = set_en_q;
    tog_en_d    = tog_en_q;
    flags_d     = flags_q;
    if (wr_at(tcc_pkg::TRIG_CTRL_ADDR))
    begin
      trig_ctrl_d = sfr_req_in.wdata;
    end
    if (wr_at(tcc_pkg::SET_ENABLE_ADDR))
    begin
      set_en_d = sfr_req_in.wdata;
    end
    if (wr_at(tcc_pkg::TOG_ENABLE_ADDR))
    begin
      tog_en_d = sfr_req_in.wdata;
    end
    // software may set or clear; a writing one requests the interrupt
    if (wr_at(tcc_pkg::FLAGS_ADDR))
    begin
      flags_d = sfr_req_in.wdata[6:0];
    end
    // hardware set wins over a clear in the same cycle
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++)
    begin
      if (cmp_hit[i])
      begin
        flags_d[tcc_pkg::FLAG_CMP_LSB + i] = 1'b1;
      end
    end
    for (int i = 0; i < tcc_pkg::NUM_CAP; i++)
    begin
      if (cap_enabled[i] ? cap_event[i] : ext_int_event_in[i])
      begin
        flags_d[tcc_pkg::FLAG_CAP_LSB + i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      trig_ctrl_q <= tcc_pkg::BYTE_RESET;
      set_en_q    <= tcc_pkg::BYTE_RESET;
      tog_en_q    <= tcc_pkg::BYTE_RESET;
      flags_q     <= tcc_pkg::FLAGS_RESET;
    end
    else
    begin
      trig_ctrl_q <= trig_ctrl_d;
      set_en_q    <= set_en_d;
      tog_en_q    <= tog_en_d;
      flags_q     <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare output port latch

  always_comb
  begin
    port_d = port_q;
    if (port_write_in)
    begin
      port_d = port_wdata_in;
    end
    // match actions take effect after a same-cycle port write
    if (cmp_hit[0] | cmp_hit[1])
    begin
      port_d[tcc_pkg::SET_PIN_COUNT-1:0] = port_d[tcc_pkg::SET_PIN_COUNT-1:0] |
                                           set_en_q[tcc_pkg::SET_PIN_COUNT-1:0];
    end
    if (cmp_hit[2])
    begin
      port_d[tcc_pkg::TOG_HI_PIN] = port_d[tcc_pkg::TOG_HI_PIN] ^ tog_en_q[tcc_pkg::TOG_HI_BIT];
      port_d[tcc_pkg::TOG_LO_PIN] = port_d[tcc_pkg::TOG_LO_PIN] ^ tog_en_q[tcc_pkg::TOG_LO_BIT];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      port_q <= tcc_pkg::BYTE_RESET;
    end
    else
    begin
      port_q <= port_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read path

  always_comb
  begin
    rdata_d = rdata_q;
    hit_d   = 1'b0;
    if (sfr_req_in.rd)
    begin
      hit_d   = mapped(sfr_req_in.addr);
      rdata_d = 8'h00;
      if (sfr_req_in.addr == tcc_pkg::FLAGS_ADDR)
      begin
        rdata_d = {1'b0, flags_q};
      end
      if (sfr_req_in.addr == tcc_pkg::TRIG_CTRL_ADDR)
      begin
        rdata_d = trig_ctrl_q;
      end
      if (sfr_req_in.addr == tcc_pkg::SET_ENABLE_ADDR)
      begin
        rdata_d = set_en_q;
      end
      if (sfr_req_in.addr == tcc_pkg::TOG_ENABLE_ADDR)
      begin
        rdata_d = tog_en_q;
      end
      for (int i = 0; i < tcc_pkg::NUM_CMP; i++)
      begin
        if (sfr_req_in.addr == tcc_pkg::CMP_LOW_ADDR[i])
        begin
          rdata_d = cmp_low_q[i];
        end
        if (sfr_req_in.addr == tcc_pkg::CMP_HIGH_ADDR[i])
        begin
          rdata_d = cmp_high_q[i];
        end
      end
      for (int i = 0; i < tcc_pkg::NUM_CAP; i++)
      begin
        if (sfr_req_in.addr == tcc_pkg::CAP_LOW_ADDR[i])
        begin
          rdata_d = cap_low_q[i];
        end
        if (sfr_req_in.addr == tcc_pkg::CAP_HIGH_ADDR[i])
        begin
          rdata_d = cap_high_q[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_q <= tcc_pkg::BYTE_RESET;
      hit_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_out           = rdata_q;
  assign sfr_hit_out             = hit_q;
  assign compare_output_port_out = port_q;
  assign compare_irq_out[1:0]    = flags_q[tcc_pkg::FLAG_CMP_LSB +: 2] & cmp_irq_enable_in[1:0];
  assign compare_irq_out[2]      = flags_q[tcc_pkg::FLAG_CMP_LSB + 2] & cmp_irq_enable_in[2];
  assign capture_irq_out         = flags_q[tcc_pkg::FLAG_CAP_LSB +: 4] & cap_irq_enable_in;

endmodule

// ---- shared/tcc_pkg.sv ----
package tcc_pkg;

  localparam int NUM_CMP = 3;
  localparam int NUM_CAP = 4;

  // sfr offsets, index = channel
  localparam logic [2:0][7:0] CMP_LOW_ADDR  = {8'hab, 8'haa, 8'ha9};
  localparam logic [2:0][7:0] CMP_HIGH_ADDR = {8'hcb, 8'hca, 8'hc9};
  localparam logic [3:0][7:0] CAP_LOW_ADDR  = {8'haf, 8'hae, 8'had, 8'hac};
  localparam logic [3:0][7:0] CAP_HIGH_ADDR = {8'hcf, 8'hce, 8'hcd, 8'hcc};
  localparam logic [7:0] FLAGS_ADDR       = 8'hc8;
  localparam logic [7:0] TRIG_CTRL_ADDR   = 8'heb;
  localparam logic [7:0] SET_ENABLE_ADDR  = 8'hee;
  localparam logic [7:0] TOG_ENABLE_ADDR  = 8'hef;

  // reset values
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // field positions
  localparam int FLAG_CMP_LSB   = 4;
  localparam int FLAG_CAP_LSB   = 0;
  localparam int SET_PIN_COUNT  = 6;
  localparam int TOG_HI_BIT     = 1;
  localparam int TOG_LO_BIT     = 0;
  localparam int TOG_HI_PIN     = 7;
  localparam int TOG_LO_PIN     = 6;

  // special-function register access, one request per clock
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tcc_sfr_req_t;

endpackage

// ---- src/tcc_edge_sync.sv ----
`timescale 1ns/100ps
module tcc_edge_sync
(
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_q;
  logic       level_d;
  logic       agree;

  assign agree = (sync_q[1] == sync_q[2]);

  always_comb
  begin
    sync_d  = {sync_q[1:0], pin_in};
    level_d = agree ? sync_q[2] : level_q;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end
    else
    begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  assign rise_out = agree & sync_q[2] & ~level_q;
  assign fall_out = agree & ~sync_q[2] & level_q;

endmodule

// ---- src/tcc_compare_match.sv ----
`timescale 1ns/100ps
module tcc_compare_match
(
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [15:0] timer_in,
  input  wire logic [15:0] value_in,
  output logic             hit_out
);

  logic equal;
  logic equal_q;
  logic equal_d;

  assign equal = (timer_in == value_in);

  always_comb
  begin
    equal_d = equal;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      // starts high: zero timer against zero compare after reset is no match
      equal_q <= 1'b1;
    end
    else
    begin
      equal_q <= equal_d;
    end
  end

  // one pulse per entry into equality, so a stalled timer fires once
  assign hit_out = equal & ~equal_q;

endmodule

// ---- testbench/tcc_pin_model.sv ----
`timescale 1ns/100ps
// far-side pin driver: trigger pins change on the rising edge of ref_clk_in, the clock the sampler uses
module tcc_pin_model
(
  input  wire logic       ref_clk_in,
  input  wire logic [3:0] level_in,
  output logic      [3:0] trigger_pin_out
);
  initial trigger_pin_out = 4'h0;
  always @(posedge ref_clk_in) trigger_pin_out <= level_in;
endmodule

// ---- testbench/tcc_capture_compare_monitor.sv ----
`timescale 1ns/100ps
module tcc_capture_compare_monitor
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  input  wire tcc_pkg::tcc_sfr_req_t sfr_req_in,
  input  wire logic [7:0]            sfr_rdata_out,
  input  wire logic                  sfr_hit_out,
  input  wire logic [2:0]            cmp_irq_enable_in,
  input  wire logic [3:0]            cap_irq_enable_in,
  input  wire logic                  port_write_in,
  input  wire logic [7:0]            compare_output_port_out,
  input  wire logic [2:0]            compare_irq_out,
  input  wire logic [3:0]            capture_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_hit_after_read: assert property (sfr_hit_out |-> $past(sfr_req_in.rd))
    else $error("hit without read");
  a_flags_read_hit: assert property (sfr_req_in.rd && sfr_req_in.addr == 8'hc8 |=> sfr_hit_out)
    else $error("flags read not answered");
  a_unmapped_read: assert property (sfr_req_in.rd && sfr_req_in.addr == 8'h00
    |=> !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("unmapped read answered");
  a_rdata_holds: assert property (!$past(sfr_req_in.rd) |-> $stable(sfr_rdata_out))
    else $error("read data moved");
  a_cmp_irq_gate: assert property ((compare_irq_out & ~cmp_irq_enable_in) == 3'h0)
    else $error("compare irq not gated");
  a_cap_irq_gate: assert property ((capture_irq_out & ~cap_irq_enable_in) == 4'h0)
    else $error("capture irq not gated");
  a_set_pins_kept: assert property (|($past(compare_output_port_out[5:0]) & ~compare_output_port_out[5:0])
    |-> $past(port_write_in)) else $error("set pin cleared by hardware");
  a_cmp_flag_sticky: assert property (|($past(compare_irq_out) & ~compare_irq_out & cmp_irq_enable_in
    & $past(cmp_irq_enable_in)) |-> $past(sfr_req_in.wr && sfr_req_in.addr == 8'hc8))
    else $error("compare flag cleared by hardware");
  c_cmp2: cover property (compare_irq_out[2]);
  c_cap: cover property (|capture_irq_out);
  c_hit: cover property (sfr_hit_out);
endmodule

// ---- testbench/tb_tcc_capture_compare.sv ----
`timescale 1ns/100ps
module tb_tcc_capture_compare;
  logic                  ref_clk_in = 1'b0;
  logic                  rstn_in    = 1'b0;
  tcc_pkg::tcc_sfr_req_t req        = '0;
  logic [7:0]            rdata;
  logic                  hit;
  logic                  h;
  logic [15:0]           timer      = 16'h0000;
  logic [15:0]           step       = 16'h0000;
  logic [15:0]           v;
  logic [3:0]            pins;
  logic [3:0]            lvl        = 4'h0;
  logic [3:0]            ext        = 4'h0;
  logic [2:0]            cmp_en     = 3'h7;
  logic [3:0]            cap_en     = 4'hf;
  logic                  pw         = 1'b0;
  logic [7:0]            pwd        = 8'h00;
  logic [7:0]            port;
  logic [7:0]            d;
  logic [7:0]            e;
  logic [7:0]            a;
  logic [7:0]            t0;
  logic [2:0]            cirq;
  logic [3:0]            kirq;
  logic [31:0]           seed       = 32'hb7a6b8e7;
  int                    err_count  = 0;
  int                    n_compared = 0;
  int                    cycles     = 0;
  int                    i;
  int                    n;

  always #5 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) if (step != 16'h0000) timer <= timer + step;
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      err_count++;
      results();
    end
  end

  tcc_pin_model pm (.ref_clk_in(ref_clk_in), .level_in(lvl), .trigger_pin_out(pins));
  tcc_capture_compare dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .sfr_hit_out(hit), .timer2_value_in(timer), .trigger_pin_in(pins),
    .ext_int_event_in(ext), .cmp_irq_enable_in(cmp_en), .cap_irq_enable_in(cap_en),
    .port_write_in(pw), .port_wdata_in(pwd), .compare_output_port_out(port),
    .compare_irq_out(cirq), .capture_irq_out(kirq));

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] tog_exp(logic [7:0] p, logic [1:0] t);
    return {p[7] ^ t[1], p[6] ^ t[0], p[5:0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] x);
    @(negedge ref_clk_in) req = '{ad, 1'b1, 1'b0, x};
    @(negedge ref_clk_in) req = '0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [7:0] x);
    @(negedge ref_clk_in) req = '{ad, 1'b0, 1'b1, 8'h00};
    @(negedge ref_clk_in) req = '0;
    x = rdata;
    h = hit;
  endtask

  task automatic match(input logic [15:0] val);
    @(negedge ref_clk_in) timer = val ^ 16'h0001;
    @(negedge ref_clk_in) timer = val;
    repeat (4) @(negedge ref_clk_in);
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      rd(8'(8'hc8 + i), d);
      check({h, d}, 16'h0100);
    end
    rd(8'h00, d);
    check({h, d}, 16'h0000);
    for (i = 0; i < 14; i++)
    begin
      a = (i < 7) ? 8'(8'hc9 + i) : 8'(8'ha2 + i);
      e = 8'(rnd());
      wr(a, e);
      rd(a, d);
      check(d, e);
    end
    $display("test registers done");
    for (n = 0; n < 2; n++)
    begin
      pwd = 8'(rnd());
      @(negedge ref_clk_in) pw = 1'b1;
      @(negedge ref_clk_in) pw = 1'b0;
      cmp_en = 3'(rnd());
      e = 8'(rnd()) & 8'h3f;
      v = 16'(rnd());
      wr(8'hee, e);
      wr(8'(8'ha9 + n), v[7:0]);
      wr(8'(8'hc9 + n), v[15:8]);
      match(v);
      check(port, pwd | e);
      check(cirq[n], cmp_en[n]);
      rd(8'hc8, d);
      check(d[4 + n], 1'b1);
      wr(8'hc8, 8'h00);
      rd(8'hc8, d);
      check(d, 8'h00);
    end
    cmp_en = 3'h7;
    wr(8'hc8, 8'h40);
    check(cirq, 3'h4);
    for (n = 0; n < 4; n++)
    begin
      cmp_en = 3'(rnd());
      wr(8'hc8, 8'h00);
      wr(8'hef, 8'(n));
      e = port;
      v = 16'(rnd());
      wr(8'hab, v[7:0]);
      wr(8'hcb, v[15:8]);
      match(v);
      check(port, tog_exp(e, n[1:0]));
      check(cirq[2], cmp_en[2]);
    end
    $display("test compare done");
    for (n = 0; n < 4; n++)
    begin
      wr(8'heb, 8'(1 << (2 * n)));
      wr(8'hc8, 8'h00);
      cap_en = 4'(rnd());
      t0 = 8'(rnd());
      timer = {t0, t0};
      @(negedge ref_clk_in) step = 16'h0101;
      lvl[n] = 1'b1;
      repeat (8) @(negedge ref_clk_in);
      step = 16'h0000;
      rd(8'(8'hcc + n), d);
      rd(8'(8'hac + n), e);
      check({d, e}, {t0, t0} + 16'h0101 * 16'(8'(e - t0)));
      check(8'(e - t0) < 8'h09, 1'b1);
      check(kirq[n], cap_en[n]);
      wr(8'hc8, 8'h00);
      @(negedge ref_clk_in) lvl[n] = 1'b0;
      repeat (8) @(negedge ref_clk_in);
      rd(8'hc8, d);
      check(d[n], 1'b0);
    end
    $display("test capture done");
    wr(8'heb, 8'h00);
    @(negedge ref_clk_in) ext = 4'hf;
    @(negedge ref_clk_in) ext = 4'h0;
    rd(8'hc8, d);
    check(d[3:0], 4'hf);
    $display("test external flags done");
    results();
  end
endmodule

bind tcc_capture_compare tcc_capture_compare_monitor mon (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
  .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
  .cmp_irq_enable_in(cmp_irq_enable_in), .cap_irq_enable_in(cap_irq_enable_in),
  .port_write_in(port_write_in), .compare_output_port_out(compare_output_port_out),
  .compare_irq_out(compare_irq_out), .capture_irq_out(capture_irq_out));
